// [verilog/esss_status.sv]
// Purpose: E1 receive slip and multiframe alignment status register bank.
// Assumes: Framer events arrive as one-cycle pulses on i_clock.
// Notes: Reading the status register clears the sticky full flag.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Bit 4 reads 1 while CAS multiframe lock is declared; resets to 0.
// - Loss of CAS lock after a programmed count of consecutive bad signals.
// - CAS lock declared by the software-selected CAS alignment algorithm.
// - Bit 3 shows current CRC multiframe lock state; resets to 0.
// - CRC lock declared by a software-selected declaration criterion.
// - CRC lock lost by a software-selected loss criterion.
// - Bit 2 is a sticky full flag, cleared when the register is read.
// - Full event raised when the receive slip buffer becomes filled.
// - Write into a full slip buffer drops a frame and sets the flag.
module esss_status (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire esss_pkg::esss_wb_req_s i_wb,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_cas_mfas_ok,
	input wire logic i_cas_mfas_bad,
	input wire logic i_crc_mf_ok,
	input wire logic i_crc_mf_bad,
	input wire logic i_rx_buf_filled,
	input wire logic i_rx_buf_write,
	input wire logic i_rx_buf_at_full,
	output logic o_rx_drop_frame,
	output logic o_irq
);
	import esss_pkg::*;

	logic ack_q;
	logic [31:0] rdat_q;
	esss_cfg_s cfg_q;
	logic [2:0] irq_st_q;
	logic [2:0] irq_en_q;
	logic full_flag_q;
	esss_cas_e cas_q;
	logic [3:0] cas_bad_q;
	logic crc_lock_q;
	logic [3:0] crc_cnt_q;
	logic drop_q;
	logic req;
	logic wr;
	logic rd_status;
	logic full_ev;
	logic cas_lock;
	logic cas_lost;
	logic crc_lost;
	logic [7:0] status_v;

	// One more hit reaches the programmed run length; a limit of 0 behaves as 1.
	function automatic logic esss_reached(input logic [3:0] count, input logic [3:0] limit);
		return count + 4'h1 >= limit;
	endfunction

	assign req = i_wb.cyc && i_wb.stb && !ack_q;
	assign wr = req && i_wb.we;
	assign rd_status = req && !i_wb.we && i_wb.adr == ESSS_OFS_STATUS;
	assign cas_lock = cas_q == ESSS_CAS_LOCKED;
	assign full_ev = i_rx_buf_filled || (i_rx_buf_write && i_rx_buf_at_full);

	always_comb begin
		status_v = ESSS_STATUS_RESET;
		status_v[ESSS_BIT_CAS_LOCK] = cas_lock;
		status_v[ESSS_BIT_CRC_LOCK] = crc_lock_q;
		status_v[ESSS_BIT_RX_FULL] = full_flag_q;
	end

	// Classic single-cycle ack; ack_q blocks a second take while the master still holds stb.
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0;
		end else begin
			ack_q <= req;
			if (req && !i_wb.we) begin
				if (i_wb.adr == ESSS_OFS_STATUS) begin
					rdat_q <= {24'h0, status_v};
				end else if (i_wb.adr == ESSS_OFS_IRQ_STATUS) begin
					rdat_q <= {29'h0, irq_st_q};
				end else if (i_wb.adr == ESSS_OFS_IRQ_ENABLE) begin
					rdat_q <= {29'h0, irq_en_q};
				end else if (i_wb.adr == ESSS_OFS_CFG) begin
					rdat_q <= {19'h0, cfg_q};
				end else begin
					rdat_q <= 32'h0;
				end
			end
		end
	end

	assign o_wb_ack = ack_q;
	assign o_wb_dat = rdat_q;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			cfg_q <= '{cas_loss_count: ESSS_CAS_LOSS_COUNT_RESET, cas_algo_two_step: 1'b0,
				crc_lock_count: ESSS_CRC_LOCK_COUNT_RESET, crc_loss_count: ESSS_CRC_LOSS_COUNT_RESET};
			irq_en_q <= ESSS_IRQ_RESET;
		end else if (wr) begin
			if (i_wb.adr == ESSS_OFS_CFG) begin
				if (i_wb.sel[0]) begin
					cfg_q[7:0] <= i_wb.dat[7:0];
				end
				if (i_wb.sel[1]) begin
					cfg_q[12:8] <= i_wb.dat[12:8];
				end
			end else if (i_wb.adr == ESSS_OFS_IRQ_ENABLE && i_wb.sel[0]) begin
				irq_en_q <= i_wb.dat[2:0];
			end
		end
	end

	// Set wins over the read clear so a coincident fill is reported on the next read.
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			full_flag_q <= 1'b0;
		end else if (full_ev) begin
			full_flag_q <= 1'b1;
		end else if (rd_status) begin
			full_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			drop_q <= 1'b0;
		end else begin
			drop_q <= i_rx_buf_write && i_rx_buf_at_full;
		end
	end

	assign o_rx_drop_frame = drop_q;

	// CAS alignment: single-hit or two-hit lock, then count consecutive bad signals.
	assign cas_lost = i_cas_mfas_bad && esss_reached(cas_bad_q, cfg_q.cas_loss_count);
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			cas_q <= ESSS_CAS_HUNT;
			cas_bad_q <= 4'h0;
		end else begin
			case (cas_q)
				ESSS_CAS_HUNT: begin
					cas_bad_q <= 4'h0;
					if (i_cas_mfas_ok) begin
						cas_q <= cfg_q.cas_algo_two_step ? ESSS_CAS_VERIFY : ESSS_CAS_LOCKED;
					end
				end
				ESSS_CAS_VERIFY: begin
					if (i_cas_mfas_ok) begin
						cas_q <= ESSS_CAS_LOCKED;
					end else if (i_cas_mfas_bad) begin
						cas_q <= ESSS_CAS_HUNT;
					end
				end
				ESSS_CAS_LOCKED: begin
					if (cas_lost) begin
						cas_q <= ESSS_CAS_HUNT;
					end else if (i_cas_mfas_bad) begin
						cas_bad_q <= cas_bad_q + 4'h1;
					end else if (i_cas_mfas_ok) begin
						cas_bad_q <= 4'h0;
					end
				end
				default: begin
					cas_q <= ESSS_CAS_HUNT;
				end
			endcase
		end
	end

	// CRC alignment: consecutive good multiframes to lock, consecutive bad ones to lose it.
	assign crc_lost = i_crc_mf_bad && esss_reached(crc_cnt_q, cfg_q.crc_loss_count);
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			crc_lock_q <= 1'b0;
			crc_cnt_q <= 4'h0;
		end else if (!crc_lock_q) begin
			if (i_crc_mf_bad) begin
				crc_cnt_q <= 4'h0;
			end else if (i_crc_mf_ok) begin
				if (esss_reached(crc_cnt_q, cfg_q.crc_lock_count)) begin
					crc_lock_q <= 1'b1;
					crc_cnt_q <= 4'h0;
				end else begin
					crc_cnt_q <= crc_cnt_q + 4'h1;
				end
			end
		end else begin
			if (crc_lost) begin
				crc_lock_q <= 1'b0;
				crc_cnt_q <= 4'h0;
			end else if (i_crc_mf_bad) begin
				crc_cnt_q <= crc_cnt_q + 4'h1;
			end else if (i_crc_mf_ok) begin
				crc_cnt_q <= 4'h0;
			end
		end
	end

	// Interrupt status: bit0 full event, bit1 CAS lock change, bit2 CRC lock change.
	logic cas_lock_d1_q;
	logic crc_lock_d1_q;
	logic [2:0] irq_ev;
	logic [2:0] irq_clr;
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			cas_lock_d1_q <= 1'b0;
			crc_lock_d1_q <= 1'b0;
		end else begin
			cas_lock_d1_q <= cas_lock;
			crc_lock_d1_q <= crc_lock_q;
		end
	end
	assign irq_ev = {crc_lock_q ^ crc_lock_d1_q, cas_lock ^ cas_lock_d1_q, full_ev};
	assign irq_clr = (wr && i_wb.adr == ESSS_OFS_IRQ_CLEAR && i_wb.sel[0]) ? i_wb.dat[2:0] : 3'h0;
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_st_q <= ESSS_IRQ_RESET;
		end else begin
			irq_st_q <= irq_ev | (irq_st_q & ~irq_clr);
		end
	end
	assign o_irq = |(irq_st_q & irq_en_q);

	property p_full_sets;
		@(posedge i_clock) disable iff (!i_nrst)
		full_ev |=> full_flag_q;
	endproperty
	a_full_sets: assert property (p_full_sets) else $error("full flag not set");

	property p_read_clears;
		@(posedge i_clock) disable iff (!i_nrst)
		rd_status && !full_ev |=> !full_flag_q;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("read did not clear");

	property p_set_wins;
		@(posedge i_clock) disable iff (!i_nrst)
		rd_status && full_ev |=> full_flag_q;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("coincident event lost");

	property p_flag_holds;
		@(posedge i_clock) disable iff (!i_nrst)
		full_flag_q && !rd_status |=> full_flag_q;
	endproperty
	a_flag_holds: assert property (p_flag_holds) else $error("flag dropped");

	property p_drop;
		@(posedge i_clock) disable iff (!i_nrst)
		i_rx_buf_write && i_rx_buf_at_full |=> o_rx_drop_frame;
	endproperty
	a_drop: assert property (p_drop) else $error("frame not dropped");

	property p_cas_loss;
		@(posedge i_clock) disable iff (!i_nrst)
		cas_lock && cas_lost |=> !cas_lock;
	endproperty
	a_cas_loss: assert property (p_cas_loss) else $error("CAS loss missed");

	property p_cas_one_step;
		@(posedge i_clock) disable iff (!i_nrst)
		cas_q == ESSS_CAS_HUNT && i_cas_mfas_ok && !cfg_q.cas_algo_two_step |=> cas_lock;
	endproperty
	a_cas_one_step: assert property (p_cas_one_step) else $error("CAS lock missed");

	property p_cas_bit;
		@(posedge i_clock) disable iff (!i_nrst)
		ack_q && $past(rd_status) |-> o_wb_dat[ESSS_BIT_CAS_LOCK] == $past(cas_lock);
	endproperty
	a_cas_bit: assert property (p_cas_bit) else $error("CAS bit wrong");

	property p_crc_bit;
		@(posedge i_clock) disable iff (!i_nrst)
		ack_q && $past(rd_status) |-> o_wb_dat[ESSS_BIT_CRC_LOCK] == $past(crc_lock_q);
	endproperty
	a_crc_bit: assert property (p_crc_bit) else $error("CRC bit wrong");

	property p_crc_loss;
		@(posedge i_clock) disable iff (!i_nrst)
		crc_lock_q && crc_lost |=> !crc_lock_q;
	endproperty
	a_crc_loss: assert property (p_crc_loss) else $error("CRC loss missed");

	property p_crc_lock;
		@(posedge i_clock) disable iff (!i_nrst)
		!crc_lock_q && i_crc_mf_ok && !i_crc_mf_bad && crc_cnt_q + 4'h1 >= cfg_q.crc_lock_count
			|=> crc_lock_q;
	endproperty
	a_crc_lock: assert property (p_crc_lock) else $error("CRC lock missed");

	property p_fill_event;
		@(posedge i_clock) disable iff (!i_nrst)
		i_rx_buf_filled |=> full_flag_q && irq_st_q[0];
	endproperty
	a_fill_event: assert property (p_fill_event) else $error("fill event missed");

	sequence s_flag_read;
		full_flag_q && rd_status && !full_ev;
	endsequence
	sequence s_flag_reported;
		o_wb_ack && o_wb_dat[ESSS_BIT_RX_FULL] && !full_flag_q;
	endsequence
	property p_flag_reported;
		@(posedge i_clock) disable iff (!i_nrst)
		s_flag_read |=> s_flag_reported;
	endproperty
	a_flag_reported: assert property (p_flag_reported) else $error("flag not reported");

	sequence s_cas_first_hit;
		cas_q == ESSS_CAS_HUNT && i_cas_mfas_ok && cfg_q.cas_algo_two_step;
	endsequence
	sequence s_cas_second_hit;
		cas_q == ESSS_CAS_VERIFY && i_cas_mfas_ok;
	endsequence
	sequence s_cas_verify_miss;
		cas_q == ESSS_CAS_VERIFY && i_cas_mfas_bad && !i_cas_mfas_ok;
	endsequence
	property p_cas_first_hit;
		@(posedge i_clock) disable iff (!i_nrst)
		s_cas_first_hit |=> cas_q == ESSS_CAS_VERIFY;
	endproperty
	a_cas_first_hit: assert property (p_cas_first_hit) else $error("CAS locked on one hit");

	property p_cas_second_hit;
		@(posedge i_clock) disable iff (!i_nrst)
		s_cas_second_hit |=> cas_lock;
	endproperty
	a_cas_second_hit: assert property (p_cas_second_hit) else $error("CAS second hit missed");

	property p_cas_verify_miss;
		@(posedge i_clock) disable iff (!i_nrst)
		s_cas_verify_miss |=> cas_q == ESSS_CAS_HUNT;
	endproperty
	a_cas_verify_miss: assert property (p_cas_verify_miss) else $error("CAS miss kept");

	property p_cas_early_loss;
		@(posedge i_clock) disable iff (!i_nrst)
		cas_lock && i_cas_mfas_bad && cas_bad_q == 4'h0 && cfg_q.cas_loss_count > 4'h1
			|=> cas_lock;
	endproperty
	a_cas_early_loss: assert property (p_cas_early_loss) else $error("CAS lost early");

	sequence s_wb_take;
		i_wb.cyc && i_wb.stb && !o_wb_ack;
	endsequence
	sequence s_wb_single_ack;
		o_wb_ack ##1 !o_wb_ack;
	endsequence
	property p_wb_answer;
		@(posedge i_clock) disable iff (!i_nrst)
		s_wb_take |=> s_wb_single_ack;
	endproperty
	a_wb_answer: assert property (p_wb_answer) else $error("ack not a one-cycle answer");
endmodule

`default_nettype wire

// [verilog/esss_pkg.sv]
// Purpose: Shared constants and types for the E1 slip and multiframe status block.
// Assumes: Classic Wishbone slave with 32-bit data and byte addresses.
// Notes: The status register offset and the interrupt registers sit at locally chosen offsets.
package esss_pkg;
	localparam logic [7:0] ESSS_OFS_STATUS = 8'h08;
	localparam logic [7:0] ESSS_OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] ESSS_OFS_IRQ_ENABLE = 8'h14;
	localparam logic [7:0] ESSS_OFS_IRQ_CLEAR = 8'h18;
	localparam logic [7:0] ESSS_OFS_CFG = 8'h1c;
	localparam int ESSS_BIT_CAS_LOCK = 4;
	localparam int ESSS_BIT_CRC_LOCK = 3;
	localparam int ESSS_BIT_RX_FULL = 2;
	localparam logic [7:0] ESSS_STATUS_RESET = 8'h00;
	localparam logic [2:0] ESSS_IRQ_RESET = 3'h0;
	localparam logic [3:0] ESSS_CAS_LOSS_COUNT_RESET = 4'h2;
	localparam logic [3:0] ESSS_CRC_LOSS_COUNT_RESET = 4'h4;
	localparam logic [3:0] ESSS_CRC_LOCK_COUNT_RESET = 4'h2;

	typedef struct packed {
		logic [3:0] cas_loss_count;
		logic cas_algo_two_step;
		logic [3:0] crc_lock_count;
		logic [3:0] crc_loss_count;
	} esss_cfg_s;

	localparam int ESSS_CFG_W = 13;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} esss_wb_req_s;

	typedef enum logic [1:0] {
		ESSS_CAS_HUNT = 2'b00,
		ESSS_CAS_VERIFY = 2'b01,
		ESSS_CAS_LOCKED = 2'b11
	} esss_cas_e;
endpackage

// [bench/esss_tb.sv]
// Purpose: Self-checking bench for the slip and multiframe status block.
// Assumes: Registered one-cycle Wishbone ack, one-cycle framer pulses, reset configuration.
// Notes: Events raised with a read request meet the taking edge of that read.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import esss_pkg::*;
	localparam logic [5:0] CO = 6'h01, CB = 6'h02, KO = 6'h04, KB = 6'h08, FL = 6'h10, WR = 6'h20;
	localparam logic [31:0] SC = 32'h10, SK = 32'h08, SF = 32'h04;
	logic i_clock, i_nrst, at_full;
	logic [5:0] ev;
	esss_wb_req_s wb_req;
	logic [31:0] o_wb_dat, q;
	logic o_wb_ack, o_rx_drop_frame, o_irq;
	int failures, comparisons, drops;

	esss_status u_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_wb(wb_req), .o_wb_dat(o_wb_dat),
		.o_wb_ack(o_wb_ack), .i_cas_mfas_ok(ev[0]), .i_cas_mfas_bad(ev[1]), .i_crc_mf_ok(ev[2]),
		.i_crc_mf_bad(ev[3]), .i_rx_buf_filled(ev[4]), .i_rx_buf_write(ev[5]),
		.i_rx_buf_at_full(at_full), .o_rx_drop_frame(o_rx_drop_frame), .o_irq(o_irq));

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Events in m go up with the request, so they land on the edge that takes it.
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [5:0] m);
		int n;
		n = 0;
		@(posedge i_clock);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
		ev <= m;
		do begin
			@(posedge i_clock);
			ev <= '0;
			n++;
		end while (o_wb_ack !== 1'b1 && n < 20);
		if (n >= 20) failures++;
		q = o_wb_dat;
		wb_req <= '0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0, 6'h0);
		chk(nm, q, e);
	endtask

	task pls(input logic [5:0] m);
		@(posedge i_clock);
		ev <= m;
		@(posedge i_clock);
		ev <= '0;
	endtask

	task ci(input logic e);
		@(posedge i_clock);
		chk("irq", {31'h0, o_irq}, {31'h0, e});
	endtask

	task conclude;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end

	always @(posedge i_clock) begin
		if (o_rx_drop_frame === 1'b1) drops++;
	end

	// The run needs under two hundred cycles; ten thousand means a hang.
	initial begin
		#1000000;
		failures++;
		conclude();
	end

	initial begin
		i_nrst = 1'b0;
		at_full = 1'b0;
		ev = '0;
		wb_req = '0;
		failures = 0;
		comparisons = 0;
		drops = 0;
		repeat (8) @(posedge i_clock);
		i_nrst <= 1'b1;
		rd(ESSS_OFS_STATUS, 32'h0, "status");
		rd(ESSS_OFS_CFG, 32'h424, "cfg");
		rd(8'h40, 32'h0, "unmapped");
		pls(CO);
		rd(ESSS_OFS_STATUS, SC, "status");
		pls(CB);
		rd(ESSS_OFS_STATUS, SC, "status");
		pls(CB);
		rd(ESSS_OFS_STATUS, 32'h0, "status");
		wb(1'b1, ESSS_OFS_CFG, 32'h524, 6'h0);
		pls(CO);
		rd(ESSS_OFS_STATUS, 32'h0, "status");
		pls(CO);
		rd(ESSS_OFS_STATUS, SC, "status");
		repeat (2) pls(CB);
		rd(ESSS_OFS_STATUS, 32'h0, "status");
		pls(CO);
		pls(CB);
		pls(CO);
		rd(ESSS_OFS_STATUS, 32'h0, "status");
		pls(KO);
		rd(ESSS_OFS_STATUS, 32'h0, "status");
		pls(KO);
		rd(ESSS_OFS_STATUS, SK, "status");
		repeat (3) pls(KB);
		rd(ESSS_OFS_STATUS, SK, "status");
		pls(KB);
		rd(ESSS_OFS_STATUS, 32'h0, "status");
		pls(FL);
		rd(ESSS_OFS_STATUS, SF, "status");
		rd(ESSS_OFS_STATUS, 32'h0, "status");
		at_full <= 1'b1;
		pls(WR);
		at_full <= 1'b0;
		rd(ESSS_OFS_STATUS, SF, "status");
		chk("drops", 32'(drops), 32'h1);
		pls(WR);
		rd(ESSS_OFS_STATUS, 32'h0, "status");
		chk("drops", 32'(drops), 32'h1);
		wb(1'b0, ESSS_OFS_STATUS, 32'h0, FL);
		rd(ESSS_OFS_STATUS, SF, "status");
		wb(1'b1, ESSS_OFS_IRQ_CLEAR, 32'h7, 6'h0);
		rd(ESSS_OFS_IRQ_STATUS, 32'h0, "irq_status");
		ci(1'b0);
		wb(1'b1, ESSS_OFS_IRQ_ENABLE, 32'h1, 6'h0);
		rd(ESSS_OFS_IRQ_ENABLE, 32'h1, "irq_enable");
		pls(FL);
		ci(1'b1);
		rd(ESSS_OFS_IRQ_STATUS, 32'h1, "irq_status");
		wb(1'b1, ESSS_OFS_IRQ_ENABLE, 32'h0, 6'h0);
		ci(1'b0);
		wb(1'b1, ESSS_OFS_IRQ_ENABLE, 32'h1, 6'h0);
		ci(1'b1);
		wb(1'b1, ESSS_OFS_IRQ_CLEAR, 32'h1, 6'h0);
		ci(1'b0);
		rd(ESSS_OFS_IRQ_STATUS, 32'h0, "irq_status");
		pls(CO);
		repeat (2) pls(KO);
		i_nrst <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_nrst <= 1'b1;
		rd(ESSS_OFS_STATUS, 32'h0, "status");
		rd(ESSS_OFS_CFG, 32'h424, "cfg");
		rd(ESSS_OFS_IRQ_ENABLE, 32'h0, "irq_enable");
		conclude();
	end
endmodule
`default_nettype wire
